// >>> dv/adc_status_general_config_regs_tb.sv
// Self-checking bench for the converter register block
`timescale 1ns/1ns
`default_nettype none
module adc_status_general_config_regs_tb
  import asg_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_write, reg_read, reg_rvalid, soft_reset_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [11:0] conv_result = 12'h000;
  logic [11:0] conv_prev = 12'h000;
  logic [11:0] data_out;
  asg_event_type ev = '0;
  asg_ctrl_type core_ctrl;
  int error_cnt = 0;
  int n_tests = 0;
  int st, gc, dc, v;
  bit ok;
  asg_host_model host (.core_clk(core_clk), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  asg_regs DUT (.core_clk(core_clk), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .core_events(ev), .conv_result(conv_result),
    .data_out(data_out), .core_ctrl(core_ctrl), .soft_reset_pulse(soft_reset_pulse));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    conv_result <= 12'($urandom);
    conv_prev <= conv_result;
  end
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input int exp);
    host.rd(a, d, ok);
    if (!ok) begin
      error_cnt++;
      end_of_test();
    end else begin
      chk($sformatf("register %0d", a), {4'h0, d}, exp[11:0]);
    end
  endtask
  // One-cycle event pulse; sequencer level kept
  task automatic pulse(input logic [6:0] m);
    @(posedge core_clk);
    ev <= m | {ev.sequencer_running, 6'h00};
    @(posedge core_clk);
    ev <= {ev.sequencer_running, 6'h00};
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h1C9F));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    st = 'h81;
    gc = 0;
    dc = 0;
    rd(8'h00, st);
    rd(8'h01, gc);
    rd(8'h02, dc);
    rd(8'h03, 0);
    host.wr(8'h00, 8'h00);
    rd(8'h00, st);
    host.wr(8'h00, 8'h01);
    st = 'h80;
    rd(8'h00, st);
    @(posedge core_clk);
    ev.sequencer_running <= 1'b1;
    pulse(7'h20);
    st = 'hC8;
    rd(8'h00, st);
    host.wr(8'h00, 8'h08);
    st = 'hC0;
    rd(8'h00, st);
    pulse(7'h02);
    pulse(7'h18);
    host.wr(8'h00, 8'h04);
    st = 'hC5;
    rd(8'h00, st);
    repeat (4) begin
      v = $urandom & 'hFE;
      host.wr(8'h01, v[7:0]);
      gc = v & 'h76;
      rd(8'h01, gc);
      chk("ctrl", {core_ctrl.crc_enable, core_ctrl.statistics_enable,
        core_ctrl.window_compare_enable, core_ctrl.window_compare_reset,
        core_ctrl.force_all_analog}, {gc[6], gc[5], gc[4], ~gc[4], gc[2]});
    end
    for (int i = 0; i < 4; i++) begin
      v = ($urandom & 'h4C) | (i << 4) | i;
      host.wr(8'h02, v[7:0]);
      dc = v & 'hB3;
      rd(8'h02, dc);
      chk("format", {core_ctrl.append_select, core_ctrl.clock_format_select}, {i[1:0], i[1:0]});
    end
    @(posedge core_clk);
    #1 chk("data", data_out, conv_prev);
    host.wr(8'h02, 8'h80);
    dc = 'h80;
    repeat (3) @(posedge core_clk);
    #1 chk("pattern", data_out, FIXED_PATTERN_CODE);
    host.wr(8'h01, 8'h02);
    rd(8'h01, 'h02);
    pulse(7'h01);
    rd(8'h01, 0);
    pulse(7'h04);
    rd(8'h00, st);
    host.wr(8'h01, 8'h40);
    pulse(7'h04);
    st = 'hC7;
    rd(8'h00, st);
    host.wr(8'h02, 8'h33);
    rd(8'h02, dc);
    host.wr(8'h01, 8'h50);
    rd(8'h01, 'h50);
    host.wr(8'h00, 8'h02);
    host.wr(8'h02, 8'h33);
    rd(8'h00, 'hC5);
    rd(8'h02, 'h33);
    host.wr(8'h01, 8'h01);
    rd(8'h00, 'hC1);
    rd(8'h01, 0);
    rd(8'h02, 0);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> dv/asg_host_model.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ns
`default_nettype none
module asg_host_model (
  // Clock
  input wire logic core_clk,
  // Register access
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(posedge core_clk);
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> dv/asg_regs_checker.sv
// Assertion checker for the converter register block
`timescale 1ns/1ns
`default_nettype none
module asg_regs_checker
  import asg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register access
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Core side
  input wire asg_event_type core_events,
  input wire logic [11:0] conv_result,
  input wire logic [11:0] data_out,
  input wire asg_ctrl_type core_ctrl,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_status_top: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata[7])
    else $error("status top bit low");
  a_seq_live: assert property (reg_read && reg_addr == 8'h00
    && $stable(core_events.sequencer_running)
    |=> reg_rdata[6] == $past(core_events.sequencer_running))
    else $error("sequencer bit wrong");
  a_gcfg_rsvd: assert property (reg_read && reg_addr == 8'h01
    |=> (reg_rdata & 8'h89) == 8'h00)
    else $error("general config reserved bits set");
  a_dcfg_rsvd: assert property (reg_read && reg_addr == 8'h02
    |=> (reg_rdata & 8'h4C) == 8'h00)
    else $error("data config reserved bits set");
  a_unmapped_zero: assert property (reg_read && reg_addr > 8'h02 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pattern_code: assert property (core_ctrl.fixed_pattern_out [*2]
    |-> data_out == FIXED_PATTERN_CODE)
    else $error("fixed pattern missing");
  a_window_reset: assert property ($fell(core_ctrl.window_compare_enable)
    |-> core_ctrl.window_compare_reset)
    else $error("window comparator not reset");
  a_cal_pulse: assert property (core_ctrl.calibration_start |=> !core_ctrl.calibration_start)
    else $error("calibration start too long");
  a_stats_clear: assert property (core_ctrl.statistics_clear
    |-> ##[0:2] core_ctrl.statistics_enable)
    else $error("statistics clear without enable");
  a_swrst_pulse: assert property (reg_write && reg_addr == 8'h01 && reg_wdata[0]
    |-> ##2 soft_reset_pulse)
    else $error("software reset pulse missing");
  c_pattern: cover property (core_ctrl.fixed_pattern_out);
  c_cal: cover property (core_ctrl.calibration_start);
  c_swrst: cover property (soft_reset_pulse);
endmodule
bind asg_regs asg_regs_checker u_chk (.core_clk(core_clk), .reset(reset),
  .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .core_events(core_events),
  .conv_result(conv_result), .data_out(data_out), .core_ctrl(core_ctrl),
  .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

// >>> rtl/asg_pkg.sv
// Package for the converter status and general configuration registers
package asg_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SYSTEM_STATUS_ADDR = 8'h00;
  localparam logic [7:0] GENERAL_CONFIG_ADDR = 8'h01;
  localparam logic [7:0] OUTPUT_DATA_CONFIG_ADDR = 8'h02;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SYSTEM_STATUS_RESET = 8'h81;
  localparam logic [7:0] GENERAL_CONFIG_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_DATA_CONFIG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------
  localparam int STAT_FIXED_ONE_BIT = 7;
  localparam int STAT_SEQ_BIT = 6;
  localparam int STAT_AVG_BIT = 3;
  localparam int STAT_FUSE_BIT = 2;
  localparam int STAT_CRC_BIT = 1;
  localparam int STAT_BOR_BIT = 0;

  // ---------------------------------------------------------------
  // General configuration field positions
  // ---------------------------------------------------------------
  localparam int GCFG_CRC_EN_BIT = 6;
  localparam int GCFG_STATS_BIT = 5;
  localparam int GCFG_WINDOW_BIT = 4;
  localparam int GCFG_ANALOG_BIT = 2;
  localparam int GCFG_CAL_BIT = 1;
  localparam int GCFG_SWRST_BIT = 0;
  localparam logic [7:0] GCFG_WRITABLE_MASK = 8'h76;

  // ---------------------------------------------------------------
  // Output data configuration field positions
  // ---------------------------------------------------------------
  localparam int DCFG_PATTERN_BIT = 7;
  localparam int DCFG_APPEND_LSB = 4;
  localparam int DCFG_FORMAT_LSB = 0;
  localparam logic [7:0] DCFG_WRITABLE_MASK = 8'hB3;

  // ---------------------------------------------------------------
  // Data path constants
  // ---------------------------------------------------------------
  localparam logic [11:0] FIXED_PATTERN_CODE = 12'hA5A;

  // Append field encodings
  localparam logic [1:0] APPEND_NONE = 2'h0;
  localparam logic [1:0] APPEND_CHANNEL_ID = 2'h1;
  localparam logic [1:0] APPEND_STATUS_FLAGS = 2'h2;
  localparam logic [1:0] APPEND_RESERVED = 2'h3;

  // Clock format encodings
  localparam logic [1:0] FORMAT_MODE0 = 2'h0;
  localparam logic [1:0] FORMAT_MODE1 = 2'h1;
  localparam logic [1:0] FORMAT_MODE2 = 2'h2;
  localparam logic [1:0] FORMAT_MODE3 = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic crc_enable;
    logic statistics_enable;
    logic statistics_clear;
    logic window_compare_enable;
    logic window_compare_reset;
    logic force_all_analog;
    logic calibration_start;
    logic fixed_pattern_out;
    logic [1:0] append_select;
    logic [1:0] clock_format_select;
  } asg_ctrl_type;

  typedef struct packed {
    logic sequencer_running;
    logic averaging_done;
    logic powerup_check_fail;
    logic powerup_check_valid;
    logic incoming_check_fail;
    logic brownout_event;
    logic calibration_done;
  } asg_event_type;

endpackage

// >>> rtl/asg_regs.sv
// Status, general configuration and output data configuration registers
`timescale 1ns/1ns
`default_nettype none

// Function
// - Status register at offset 0 resets to 0x81; bit 7 always reads one.
// - Status bit 6 reads the live sequencer running state.
// - Status bit 3 sets when averaging completes.
// - Writing one to status bit 3 clears the averaging flag.
// - Status bit 2 shows power-up check failure; re-evaluated after reset.
// - Status bit 1 sets on incoming CRC failure; write one clears.
// - While CRC error set, writes above offset 1 are dropped.
// - Status bit 0 resets to one, sets on brown-out, write one clears.
// - General config at offset 1 resets zero; bits 7 and 3 read-only.
// - General config bit 6 enables CRC append and incoming check.
// - Bit 5 low freezes statistics; setting it clears then updates them.
// - Bit 4 enables window comparator; zero disables and resets it.
// - Bit 2 forces all eight channels to analog inputs.
// - Writing bit 1 starts offset calibration; clears itself when done.
// - Writing bit 0 resets all registers, self-clears, sets brown-out flag.
// - Data config at offset 2 resets zero with pattern, append, format fields.
// - Pattern bit makes data reads return constant 0xA5A.
// - Append field: none, channel id, status flags, reserved.
// - Two-bit field selects clock polarity and phase format.
module asg_regs
  import asg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register access from the serial interface
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Events from the converter core
  input wire asg_event_type core_events,
  // Data path conversion result
  input wire logic [11:0] conv_result,
  output logic [11:0] data_out,
  // Controls to the converter core
  output asg_ctrl_type core_ctrl,
  output logic soft_reset_pulse
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic write_status;
  logic write_general;
  logic write_data_cfg;
  logic crc_error;
  logic avg_flag;
  logic bor_flag;
  logic fuse_fail_reg;
  logic seq_running_reg;
  logic [7:0] general_reg;
  logic [7:0] data_cfg_reg;
  logic soft_reset_reg;
  logic cal_busy_reg;
  logic stats_prev_reg;
  logic regs_reset;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  assign write_status = reg_write && addr_hit(reg_addr, SYSTEM_STATUS_ADDR);
  assign write_general = reg_write && addr_hit(reg_addr, GENERAL_CONFIG_ADDR);
  assign write_data_cfg = reg_write && addr_hit(reg_addr, OUTPUT_DATA_CONFIG_ADDR)
                          && !crc_error;
  assign regs_reset = reset || soft_reset_reg;

  // ---------------------------------------------------------------
  // Sticky status flags
  // ---------------------------------------------------------------
  asg_w1c_flag #(.RESET_VALUE(1'b0)) u_avg_flag (
    .core_clk(core_clk),
    .reset(regs_reset),
    .set_pulse(core_events.averaging_done),
    .clear_pulse(write_status && reg_wdata[STAT_AVG_BIT]),
    .flag(avg_flag)
  );

  asg_w1c_flag #(.RESET_VALUE(1'b0)) u_crc_flag (
    .core_clk(core_clk),
    .reset(regs_reset),
    .set_pulse(core_events.incoming_check_fail && general_reg[GCFG_CRC_EN_BIT]),
    .clear_pulse(write_status && reg_wdata[STAT_CRC_BIT]),
    .flag(crc_error)
  );

  // Brown-out flag: soft reset restores its reset value of one
  asg_w1c_flag #(.RESET_VALUE(1'b1)) u_bor_flag (
    .core_clk(core_clk),
    .reset(regs_reset),
    .set_pulse(core_events.brownout_event),
    .clear_pulse(write_status && reg_wdata[STAT_BOR_BIT]),
    .flag(bor_flag)
  );

  // ---------------------------------------------------------------
  // Read-only live status
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seq_running_reg <= 1'b0;
    end else begin
      seq_running_reg <= core_events.sequencer_running;
    end
  end

  // Power-up check result latched on every valid strobe, cleared by reset
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      fuse_fail_reg <= 1'b0;
    end else if (core_events.powerup_check_valid) begin
      fuse_fail_reg <= core_events.powerup_check_fail;
    end
  end

  // ---------------------------------------------------------------
  // General configuration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      general_reg <= GENERAL_CONFIG_RESET;
    end else if (write_general) begin
      general_reg <= reg_wdata & GCFG_WRITABLE_MASK;
    end else if (core_events.calibration_done && !cal_busy_reg) begin
      general_reg[GCFG_CAL_BIT] <= 1'b0;
    end else if (core_events.calibration_done) begin
      general_reg[GCFG_CAL_BIT] <= 1'b0;
    end
  end

  // Calibration start pulse tracking
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      cal_busy_reg <= 1'b0;
    end else if (write_general && reg_wdata[GCFG_CAL_BIT]) begin
      cal_busy_reg <= 1'b1;
    end else if (core_events.calibration_done) begin
      cal_busy_reg <= 1'b0;
    end
  end

  // Software reset: one-cycle pulse, bit reads zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= write_general && reg_wdata[GCFG_SWRST_BIT];
    end
  end

  // Statistics enable edge for clearing
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      stats_prev_reg <= 1'b0;
    end else begin
      stats_prev_reg <= general_reg[GCFG_STATS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Output data configuration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      data_cfg_reg <= OUTPUT_DATA_CONFIG_RESET;
    end else if (write_data_cfg) begin
      data_cfg_reg <= reg_wdata & DCFG_WRITABLE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Controls to the core
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      core_ctrl <= '0;
      core_ctrl.window_compare_reset <= 1'b1;
    end else begin
      core_ctrl.crc_enable <= general_reg[GCFG_CRC_EN_BIT];
      core_ctrl.statistics_enable <= general_reg[GCFG_STATS_BIT];
      core_ctrl.statistics_clear <= general_reg[GCFG_STATS_BIT] && !stats_prev_reg;
      core_ctrl.window_compare_enable <= general_reg[GCFG_WINDOW_BIT];
      core_ctrl.window_compare_reset <= !general_reg[GCFG_WINDOW_BIT];
      core_ctrl.force_all_analog <= general_reg[GCFG_ANALOG_BIT];
      core_ctrl.calibration_start <= write_general && reg_wdata[GCFG_CAL_BIT];
      core_ctrl.fixed_pattern_out <= data_cfg_reg[DCFG_PATTERN_BIT];
      core_ctrl.append_select <= data_cfg_reg[DCFG_APPEND_LSB +: 2];
      core_ctrl.clock_format_select <= data_cfg_reg[DCFG_FORMAT_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_reset_reg;
    end
  end

  // ---------------------------------------------------------------
  // Data path output
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (regs_reset) begin
      data_out <= '0;
    end else if (data_cfg_reg[DCFG_PATTERN_BIT]) begin
      data_out <= FIXED_PATTERN_CODE;
    end else begin
      data_out <= conv_result;
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  function automatic logic [7:0] status_word(input logic seq, input logic avg,
                                             input logic fuse, input logic crc,
                                             input logic bor);
    logic [7:0] w;
    w = 8'h00;
    w[STAT_FIXED_ONE_BIT] = 1'b1;
    w[STAT_SEQ_BIT] = seq;
    w[STAT_AVG_BIT] = avg;
    w[STAT_FUSE_BIT] = fuse;
    w[STAT_CRC_BIT] = crc;
    w[STAT_BOR_BIT] = bor;
    status_word = w;
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        case (reg_addr)
          SYSTEM_STATUS_ADDR: begin
            reg_rdata <= status_word(seq_running_reg, avg_flag, fuse_fail_reg,
                                     crc_error, bor_flag);
          end
          GENERAL_CONFIG_ADDR: begin
            reg_rdata <= general_reg & GCFG_WRITABLE_MASK;
          end
          OUTPUT_DATA_CONFIG_ADDR: begin
            reg_rdata <= data_cfg_reg & DCFG_WRITABLE_MASK;
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/asg_w1c_flag.sv
// Sticky flag with write-one-to-clear where a set beats a clear
`timescale 1ns/1ns
`default_nettype none
module asg_w1c_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic set_pulse,
  input wire logic clear_pulse,
  // State
  output logic flag
);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag <= RESET_VALUE;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clear_pulse) begin
      flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire
